// ===== rtl/ppl_pkg.sv
// Notes on behaviour
// - buffer size default 128, never above 4096
// - buffer size written as 16-bit byte count
// - load transfer counter, check status first
// - command 43H reads port, C3H writes
// - block size multiple of 8 bytes
// - block size 10 bits, default 64, max 1016
// - buffer size 33H/B3H, block size 53H
// - never clear skip bit of empty block
// - last-descriptor bitmap marks final entry
// - skip 18H/98H, last-descriptor 99H
// - read active index before adding descriptors
// - completion 17H, active index 1AH, read-only
// - port moves 16-bit words per byte count
package ppl_pkg;
  localparam int CLK_MHZ      = 20;
  localparam int T_STROBE_NS  = 150;
  localparam int STROBE_CYC   = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC     = 3;
  localparam int ACC_CYC      = STROBE_CYC + SYNC_CYC;
  localparam int T_POLL_US    = 1000;
  localparam int POLL_CYC_DEF = T_POLL_US * CLK_MHZ;
  localparam logic [3:0] TMR_END = 4'(ACC_CYC);
  localparam logic [3:0] TMR_FIN = 4'(ACC_CYC + 1);

  localparam int SW_AW = 8;
  localparam int DW    = 16;
  localparam logic [7:0] A_OP     = 8'h00;
  localparam logic [7:0] A_WDATA  = 8'h04;
  localparam logic [7:0] A_RDATA  = 8'h08;
  localparam logic [7:0] A_PORT   = 8'h0C;
  localparam logic [7:0] A_PWORD  = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_DONE   = 8'h18;
  localparam logic [7:0] A_ADDR   = 8'h1C;
  localparam logic [7:0] A_CTRL   = 8'h20;
  localparam logic [7:0] A_SIZE   = 8'h24;

  localparam int ST_BUSY = 0;
  localparam int ST_ERR  = 1;
  localparam int ST_EOT  = 2;
  localparam int ST_WAIT = 3;
  localparam int ST_FULL = 4;
  localparam int PORT_DIR = 16;
  localparam int CTRL_POLL = 0;
  localparam int CODE_DIR  = 7;

  localparam logic [7:0] C_DONE_RD = 8'h17;
  localparam logic [7:0] C_SKIP_RD = 8'h18;
  localparam logic [7:0] C_LAST_RD = 8'h19;
  localparam logic [7:0] C_ACT_RD  = 8'h1A;
  localparam logic [7:0] C_BUF_RD  = 8'h33;
  localparam logic [7:0] C_PORT_RD = 8'h43;
  localparam logic [7:0] C_BLK_RD  = 8'h53;
  localparam logic [7:0] C_SKIP_WR = 8'h98;
  localparam logic [7:0] C_LAST_WR = 8'h99;
  localparam logic [7:0] C_BUF_WR  = 8'hB3;
  localparam logic [7:0] C_PORT_WR = 8'hC3;
  localparam logic [7:0] C_BLK_WR  = 8'hD3;

  localparam logic [15:0] BUF_DEF = 16'h0080;
  localparam logic [15:0] BUF_MAX = 16'h1000;
  localparam logic [9:0]  BLK_DEF = 10'h040;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_CMD = 4'h2, S_DATA = 4'h4, S_WAIT = 4'h8
  } ppl_state_t;
  typedef enum logic [3:0] {
    PH_REG = 4'h1, PH_CNT = 4'h2, PH_STAT = 4'h4, PH_PORT = 4'h8
  } ppl_phase_t;

  // two-word register codes
  function automatic logic is32(input logic [7:0] c);
    return c == C_DONE_RD || c == C_SKIP_RD || c == C_LAST_RD ||
           c == C_SKIP_WR || c == C_LAST_WR;
  endfunction

  function automatic logic legal_code(input logic [7:0] c);
    return is32(c) || c == C_ACT_RD || c == C_BUF_RD || c == C_BUF_WR ||
           c == C_BLK_RD || c == C_BLK_WR;
  endfunction
endpackage

// ===== rtl/ppl_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppl_sync #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ppl_sync_st_t;
  ppl_sync_st_t st_reg;
  ppl_sync_st_t st_next;

  // three stages, accept bits where stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.q  = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{default: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule
`default_nettype wire

// ===== rtl/ppl_host.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ppl_host #(
  parameter int         POLL_CYC     = ppl_pkg::POLL_CYC_DEF,
  parameter logic [7:0] CNT_WR_CODE  = 8'h22,
  parameter logic [7:0] STAT_RD_CODE = 8'h2C
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [ppl_pkg::SW_AW-1:0] sw_addr,
  input  wire logic [31:0]               sw_wdata,
  input  wire logic                       sw_wr,
  input  wire logic                       sw_rd,
  output logic      [31:0]               sw_rdata,
  output logic                            dev_cs_n,
  output logic                            dev_rd_n,
  output logic                            dev_wr_n,
  output logic                            dev_a0,
  output logic      [ppl_pkg::DW-1:0]    dev_data_o,
  output logic                            dev_data_oe_n,
  input  wire logic [ppl_pkg::DW-1:0]    dev_data_i,
  input  wire logic                       dev_irq_n
);
  import ppl_pkg::*;

  typedef struct packed {
    ppl_state_t  state;
    ppl_phase_t  phase;
    logic [7:0]  code;
    logic        dir_wr;
    logic [15:0] nwords;
    logic [15:0] widx;
    logic [3:0]  tmr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [15:0] pword;
    logic        pword_full;
    logic [15:0] pcount;
    logic        pdir;
    logic [15:0] buf_size;
    logic [9:0]  blk_size;
    logic [4:0]  active;
    logic [31:0] done_acc;
    logic [15:0] buf_stat;
    logic        err;
    logic        eot;
    logic        irq_prev;
    logic        poll_en;
    logic        poll_pend;
    logic [15:0] poll_cnt;
    logic [31:0] sw_rdata;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        a0;
    logic [15:0] dout;
    logic        oe_n;
  } ppl_host_st_t;

  localparam logic [15:0] POLL_RLD = 16'(POLL_CYC - 1);
  localparam ppl_host_st_t ST_RST = '{state: S_IDLE, phase: PH_REG,
    buf_size: BUF_DEF, blk_size: BLK_DEF, irq_prev: 1'b1, poll_cnt: POLL_RLD,
    cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1, default: '0};

  ppl_host_st_t st_reg;
  ppl_host_st_t st_next;
  logic [16:0]  sync_q;
  logic [15:0]  din;
  logic         irq_s;
  logic [31:0]  done_new;
  logic [15:0]  rem;
  logic         is_cmd;
  logic         bad;

  // pin inputs cross into the clock domain
  ppl_sync #(.W(17)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({dev_irq_n, dev_data_i}),
    .q    (sync_q)
  );
  assign din   = sync_q[15:0];
  assign irq_s = sync_q[16];

  // software decode, sequencer and device pin drive
  always_comb begin
    st_next  = st_reg;
    done_new = '0;
    rem      = st_reg.nwords;
    is_cmd   = st_reg.state == S_CMD;
    bad      = 1'b0;
    case (sw_addr)
      A_WDATA:  st_next.sw_rdata = st_reg.wdata;
      A_RDATA:  st_next.sw_rdata = st_reg.rdata;
      A_PORT:   st_next.sw_rdata = {15'h0, st_reg.pdir, st_reg.pcount};
      A_PWORD:  st_next.sw_rdata = {16'h0, st_reg.pword};
      A_STATUS: st_next.sw_rdata = {st_reg.buf_stat, 11'h0, st_reg.pword_full,
                  st_reg.state == S_WAIT, st_reg.eot, st_reg.err,
                  st_reg.state != S_IDLE || st_reg.poll_pend}; // pending poll counts busy
      A_DONE:   st_next.sw_rdata = st_reg.done_acc;
      A_ADDR:   st_next.sw_rdata = {16'(st_reg.active) * 16'(st_reg.blk_size),
                  11'h0, st_reg.active};
      A_CTRL:   st_next.sw_rdata = {31'h0, st_reg.poll_en};
      A_SIZE:   st_next.sw_rdata = {6'h0, st_reg.blk_size, st_reg.buf_size};
      default:  st_next.sw_rdata = 32'h0;
    endcase
    if (!sw_rd) begin
      st_next.sw_rdata = 32'h0;
    end
    // software side effects
    if (sw_rd && sw_addr == A_PWORD && !st_reg.pdir) begin
      st_next.pword_full = 1'b0;
    end
    if (sw_wr && sw_addr == A_PWORD) begin
      if (st_reg.state != S_IDLE && st_reg.phase != PH_REG && st_reg.pdir &&
          !st_reg.pword_full) begin
        st_next.pword      = sw_wdata[15:0];
        st_next.pword_full = 1'b1;
      end else begin
        bad = 1'b1;
      end
    end
    if (sw_wr && sw_addr == A_WDATA) begin
      st_next.wdata = sw_wdata;
    end
    if (sw_wr && sw_addr == A_CTRL) begin
      st_next.poll_en = sw_wdata[CTRL_POLL];
    end
    if (sw_wr && sw_addr == A_STATUS) begin
      st_next.err = st_reg.err & ~sw_wdata[ST_ERR];
      st_next.eot = st_reg.eot & ~sw_wdata[ST_EOT];
    end
    // falling interrupt pin marks transfers ended, set wins
    st_next.irq_prev = irq_s;
    if (st_reg.irq_prev && !irq_s) begin
      st_next.eot = 1'b1;
    end
    // millisecond completion poll
    if (st_reg.poll_en) begin
      if (st_reg.poll_cnt == 16'h0) begin
        st_next.poll_cnt  = POLL_RLD;
        st_next.poll_pend = 1'b1;
      end else begin
        st_next.poll_cnt = st_reg.poll_cnt - 16'h1;
      end
    end
    case (st_reg.state)
      S_IDLE: begin
        st_next.tmr  = 4'h0;
        st_next.widx = 16'h0;
        if (sw_wr && sw_addr == A_OP) begin
          if (!legal_code(sw_wdata[7:0]) ||
              (sw_wdata[7:0] == C_BUF_WR && st_reg.wdata[15:0] > BUF_MAX) ||
              (sw_wdata[7:0] == C_BLK_WR && (st_reg.wdata[15:10] != 6'h0 ||
               st_reg.wdata[2:0] != 3'h0))) begin
            bad = 1'b1;
          end else begin
            st_next.code   = sw_wdata[7:0];
            st_next.dir_wr = sw_wdata[CODE_DIR];
            st_next.nwords = is32(sw_wdata[7:0]) ? 16'h2 : 16'h1;
            st_next.rdata  = 32'h0;
            st_next.phase  = PH_REG;
            st_next.state  = S_CMD;
            if (sw_wdata[7:0] == C_BUF_WR) begin
              st_next.buf_size = st_reg.wdata[15:0];
            end
            if (sw_wdata[7:0] == C_BLK_WR) begin
              st_next.blk_size = st_reg.wdata[9:0];
            end
          end
        end else if (sw_wr && sw_addr == A_PORT) begin
          if (sw_wdata[15:0] == 16'h0 || sw_wdata[15:0] > st_reg.buf_size) begin
            bad = 1'b1;
          end else begin
            st_next.pcount     = sw_wdata[15:0];
            st_next.pdir       = sw_wdata[PORT_DIR];
            st_next.pword_full = 1'b0;
            st_next.code       = CNT_WR_CODE;
            st_next.dir_wr     = 1'b1;
            st_next.nwords     = 16'h1;
            st_next.phase      = PH_CNT;
            st_next.state      = S_CMD;
          end
        end else if (st_reg.poll_pend) begin
          st_next.poll_pend = st_reg.poll_en && st_reg.poll_cnt == 16'h0; // set wins
          st_next.code      = C_DONE_RD;
          st_next.dir_wr    = 1'b0;
          st_next.nwords    = 16'h2;
          st_next.rdata     = 32'h0;
          st_next.phase     = PH_REG;
          st_next.state     = S_CMD;
        end
      end
      S_CMD, S_DATA: begin
        st_next.tmr = st_reg.tmr + 4'h1;
        if (st_reg.tmr < TMR_END) begin
          st_next.cs_n = 1'b0;
          st_next.a0   = is_cmd;
          st_next.wr_n = !(is_cmd || st_reg.dir_wr);
          st_next.rd_n = is_cmd || st_reg.dir_wr;
          st_next.oe_n = !(is_cmd || st_reg.dir_wr);
          if (is_cmd) begin
            st_next.dout = {8'h0, st_reg.code};
          end else if (st_reg.phase == PH_REG) begin
            st_next.dout = st_reg.widx[0] ? st_reg.wdata[31:16] : st_reg.wdata[15:0];
          end else if (st_reg.phase == PH_CNT) begin
            st_next.dout = st_reg.pcount;
          end else begin
            st_next.dout = st_reg.pword;
          end
        end else if (st_reg.tmr == TMR_END) begin
          st_next.cs_n = 1'b1;
          st_next.rd_n = 1'b1;
          st_next.wr_n = 1'b1;
          st_next.oe_n = 1'b1;
          st_next.a0   = 1'b0;
          if (!is_cmd && !st_reg.dir_wr) begin
            if (st_reg.phase == PH_REG && st_reg.widx[0]) begin
              st_next.rdata[31:16] = din;
            end else if (st_reg.phase == PH_REG) begin
              st_next.rdata[15:0] = din;
            end else if (st_reg.phase == PH_STAT) begin
              st_next.buf_stat = din;
            end else begin
              st_next.pword      = din;
              st_next.pword_full = 1'b1;
            end
          end
        end else begin
          st_next.tmr = 4'h0;
          if (!is_cmd) begin
            rem          = st_reg.nwords - 16'h1;
            st_next.widx = st_reg.widx + 16'h1;
            if (st_reg.phase == PH_PORT && st_reg.pdir) begin
              st_next.pword_full = 1'b0;
            end
          end
          st_next.nwords = rem;
          if (rem != 16'h0) begin
            if (st_reg.phase == PH_PORT && (st_reg.pdir != st_next.pword_full)) begin
              st_next.state = S_WAIT;
            end else begin
              st_next.state = S_DATA;
            end
          end else begin
            st_next.widx = 16'h0;
            case (st_reg.phase)
              PH_CNT: begin
                st_next.phase  = PH_STAT;
                st_next.code   = STAT_RD_CODE;
                st_next.dir_wr = 1'b0;
                st_next.nwords = 16'h1;
                st_next.state  = S_CMD;
              end
              PH_STAT: begin
                st_next.phase  = PH_PORT;
                st_next.code   = st_reg.pdir ? C_PORT_WR : C_PORT_RD;
                st_next.dir_wr = st_reg.pdir;
                st_next.nwords = (st_reg.pcount >> 1) + {15'h0, st_reg.pcount[0]};
                st_next.state  = S_CMD;
              end
              default: begin
                st_next.state = S_IDLE;
                if (st_reg.phase == PH_REG) begin
                  case (st_reg.code)
                    C_DONE_RD: done_new = st_reg.rdata;
                    C_ACT_RD:  st_next.active = st_reg.rdata[4:0];
                    C_BUF_RD:  st_next.buf_size = st_reg.rdata[15:0];
                    C_BLK_RD:  st_next.blk_size = st_reg.rdata[9:0];
                    default:   st_next.active = st_reg.active;
                  endcase
                end
              end
            endcase
          end
        end
      end
      S_WAIT: begin
        if (st_reg.pdir == st_reg.pword_full) begin
          st_next.state = S_DATA;
        end
      end
      default: st_next.state = S_IDLE;
    endcase
    // completion bits caught during a read stay for the next one
    st_next.done_acc = ((sw_rd && sw_addr == A_DONE) ? 32'h0 : st_reg.done_acc)
                       | done_new;
    if (bad || (sw_wr && (sw_addr == A_OP || sw_addr == A_PORT) &&
        st_reg.state != S_IDLE)) begin
      st_next.err = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign sw_rdata      = st_reg.sw_rdata;
  assign dev_cs_n      = st_reg.cs_n;
  assign dev_rd_n      = st_reg.rd_n;
  assign dev_wr_n      = st_reg.wr_n;
  assign dev_a0        = st_reg.a0;
  assign dev_data_o    = st_reg.dout;
  assign dev_data_oe_n = st_reg.oe_n;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_strobe_rest;
    !dev_cs_n [*6] ##1 dev_cs_n;
  endsequence
  sequence s_cmd_start;
    st_reg.state == S_CMD && st_reg.tmr == 4'h0;
  endsequence
  sequence s_port_entry;
    $rose(st_reg.phase == PH_PORT);
  endsequence

  AST_STROBE_LEN: assert property ($fell(dev_cs_n) |-> s_strobe_rest)
    else $error("device strobe length wrong");
  AST_CMD_DRIVE: assert property (s_cmd_start |=> !dev_cs_n && dev_a0 && !dev_wr_n
    && !dev_data_oe_n && dev_data_o == $past(st_reg.code))
    else $error("command phase not driven");
  AST_PORT_ZERO: assert property (s_port_entry |-> st_reg.widx == 16'h0)
    else $error("port transfer not from start");
  AST_CNT_FIRST: assert property (s_port_entry |-> $past(st_reg.phase) == PH_STAT)
    else $error("port used before counter and status");
  AST_PTR_STEP: assert property ((st_reg.state == S_DATA && st_reg.phase == PH_PORT
    && st_reg.tmr == TMR_FIN && st_reg.nwords > 16'h1) |=>
    st_reg.widx == $past(st_reg.widx) + 16'h1)
    else $error("port word index skipped");
  AST_BUF_MAX: assert property (st_reg.buf_size <= BUF_MAX)
    else $error("buffer size above limit");
  AST_BLK_ALIGN: assert property ($changed(st_reg.blk_size) && $past(st_reg.state) == S_IDLE
    |-> st_reg.blk_size[2:0] == 3'h0)
    else $error("block size not a multiple of eight");
  AST_DONE_KEEP: assert property ((done_new != 32'h0) |=>
    (st_reg.done_acc & $past(done_new)) == $past(done_new))
    else $error("completion bit lost");
  AST_POLL: assert property ((st_reg.poll_en && st_reg.poll_cnt == 16'h0) |=>
    st_reg.poll_pend)
    else $error("poll tick missed");
  AST_WORDS32: assert property ((s_cmd_start and (st_reg.phase == PH_REG
    && is32(st_reg.code))) |-> st_reg.nwords == 16'h2)
    else $error("bitmap access not two words");
  AST_EOT: assert property ((st_reg.irq_prev && !irq_s) |=> st_reg.eot)
    else $error("transfers ended not flagged");
endmodule
`default_nettype wire

// ===== tb/ppl_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppl_dev_model (
  input  wire logic        clk,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        a0,
  input  wire logic [15:0] din,
  output logic      [15:0] dout,
  output logic             irq_n,
  input  wire logic [31:0] done_in,
  input  wire logic        done_stb,
  input  wire logic [4:0]  act_in
);
  logic [15:0] mem [0:2047];
  logic [31:0] done    = 32'h0;
  logic [31:0] skip    = 32'h0;
  logic [31:0] last    = 32'h0;
  logic [15:0] bsz     = 16'h0080;
  logic [15:0] blk     = 16'h0040;
  logic [15:0] cnt     = 16'h0000;
  logic [15:0] ptr     = 16'h0000;
  logic [15:0] drv     = 16'h5A5A;
  logic [7:0]  code    = 8'h00;
  logic        widx    = 1'b0;
  logic        wseen   = 1'b0;
  logic        rseen   = 1'b0;
  logic [2:0]  irq_cnt = 3'h0;
  logic [15:0] rval;

  assign dout  = drv;
  assign irq_n = (irq_cnt == 3'h0);

  // word presented for the current read code
  always_comb begin
    case (code)
      8'h17:   rval = widx ? done[31:16] : done[15:0];
      8'h18:   rval = widx ? skip[31:16] : skip[15:0];
      8'h19:   rval = widx ? last[31:16] : last[15:0];
      8'h1A:   rval = {11'h000, act_in};
      8'h33:   rval = bsz;
      8'h53:   rval = blk;
      8'h43:   rval = mem[ptr[11:1]];
      8'h2C:   rval = 16'h0001; // status value arbitrary
      default: rval = 16'h0000;
    endcase
  end

  // strobe decode, released bus toggles its last value
  always @(posedge clk) begin
    if (done_stb) done <= done | done_in;
    irq_cnt <= (irq_cnt != 3'h0) ? irq_cnt - 3'h1 : 3'h0;
    wseen <= !cs_n && !wr_n;
    rseen <= !cs_n && !rd_n;
    drv <= (!cs_n && !rd_n) ? rval : ~drv;
    if (!cs_n && !wr_n && !wseen) begin
      if (a0) begin
        code <= din[7:0];
        widx <= 1'b0;
        ptr <= 16'h0000;
      end else begin
        widx <= ~widx;
        case (code)
          8'h98: skip[widx*16 +: 16] <= din;
          8'h99: last[widx*16 +: 16] <= din;
          8'hB3: bsz <= din;
          8'hD3: blk <= {6'h00, din[9:0]};
          8'h22: cnt <= din;
          8'hC3: begin
            mem[ptr[11:1]] <= din;
            ptr <= ptr + 16'h0002;
            if (ptr + 16'h0002 >= cnt) irq_cnt <= 3'h4;
          end
          default: ;
        endcase
      end
    end
    // end of a data read
    if (rseen && (cs_n || rd_n)) begin
      widx <= ~widx;
      if (code == 8'h17 && widx) done <= done_stb ? done_in : 32'h0;
      if (code == 8'h43) begin
        ptr <= ptr + 16'h0002;
        if (ptr + 16'h0002 >= cnt) irq_cnt <= 3'h4;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/ppl_host_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ppl_host_tb_top;
  import ppl_pkg::*;
  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic [7:0]  sw_addr  = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr    = 1'b0;
  logic        sw_rd    = 1'b0;
  logic [31:0] done_in  = 32'h0;
  logic        done_stb = 1'b0;
  logic [4:0]  act_in   = 5'h03;
  logic [31:0] sw_rdata;
  logic [31:0] r;
  logic        dev_cs_n, dev_rd_n, dev_wr_n, dev_a0, dev_data_oe_n, dev_irq_n;
  logic [15:0] dev_data_o, dev_data_i;
  logic [7:0]  codes [6] = '{8'h33, 8'h53, 8'h17, 8'h18, 8'h19, 8'h1A};
  logic [31:0] exps  [6] = '{32'h80, 32'h40, 32'h0, 32'h0, 32'h0, 32'h3};
  int          n_errors = 0;
  int          n_tests  = 0;

  // clock
  always #25 clk = ~clk;

  ppl_host #(.POLL_CYC(50)) dut (.clk(clk), .rstn(rstn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_cs_n(dev_cs_n), .dev_rd_n(dev_rd_n), .dev_wr_n(dev_wr_n), .dev_a0(dev_a0),
    .dev_data_o(dev_data_o), .dev_data_oe_n(dev_data_oe_n), .dev_data_i(dev_data_i),
    .dev_irq_n(dev_irq_n));

  ppl_dev_model m (.clk(clk), .cs_n(dev_cs_n), .rd_n(dev_rd_n), .wr_n(dev_wr_n),
    .a0(dev_a0), .din(dev_data_o), .dout(dev_data_i), .irq_n(dev_irq_n),
    .done_in(done_in), .done_stb(done_stb), .act_in(act_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  task automatic wait_st(input int b, input logic v);
    logic [31:0] s;
    for (int i = 0; i < 200; i++) begin
      rd(A_STATUS, s);
      if (s[b] === v) return;
    end
    chk({31'h0, s[b]}, {31'h0, v});
  endtask

  // status bit must be set, then cleared by writing one
  task automatic st_set(input int b);
    logic [31:0] s;
    rd(A_STATUS, s);
    chk({31'h0, s[b]}, 32'h1);
    wr(A_STATUS, 32'h1 << b);
  endtask

  task automatic op(input logic [7:0] c, input logic [31:0] d, output logic [31:0] q);
    wr(A_WDATA, d);
    wr(A_OP, {24'h0, c});
    wait_st(ST_BUSY, 1'b0);
    rd(A_RDATA, q);
  endtask

  task automatic post_done(input logic [31:0] v);
    @(posedge clk);
    done_in <= v;
    done_stb <= 1'b1;
    @(posedge clk);
    done_stb <= 1'b0;
  endtask

  task automatic final_report;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk({31'h0, dev_cs_n}, 32'h1);
    chk(sw_rdata, 32'h0);
    foreach (codes[i]) begin
      op(codes[i], 32'h0, r);
      chk(r, exps[i]);
    end
    // register writes and readback
    op(C_SKIP_WR, 32'hFFFF_FFFF, r);
    op(C_SKIP_RD, 32'h0, r);
    chk(r, 32'hFFFF_FFFF);
    op(C_LAST_WR, 32'h8000_0001, r);
    op(C_LAST_RD, 32'h0, r);
    chk(r, 32'h8000_0001);
    op(C_BUF_WR, 32'h0100, r);
    op(C_BUF_RD, 32'h0, r);
    chk(r, 32'h0100);
    op(C_BUF_WR, 32'h1001, r);
    st_set(ST_ERR);
    op(C_BUF_RD, 32'h0, r);
    chk(r, 32'h0100);
    op(C_BLK_WR, 32'h000C, r);
    st_set(ST_ERR);
    op(C_BLK_RD, 32'h0, r);
    chk(r, 32'h0040);
    op(C_BLK_WR, 32'h03F8, r);
    op(C_BLK_RD, 32'h0, r);
    chk(r, 32'h03F8);
    act_in <= 5'h07;
    op(C_ACT_RD, 32'h0, r);
    chk(r, 32'h0007);
    rd(A_ADDR, r);
    chk(r, 32'h1BC8_0007);
    // periodic poll of the completion map
    post_done(32'h40);
    wr(A_CTRL, 32'h1);
    repeat (150) @(posedge clk);
    wr(A_CTRL, 32'h0);
    wait_st(ST_BUSY, 1'b0);
    rd(A_DONE, r);
    chk(r, 32'h40);
    rd(A_DONE, r);
    chk(r, 32'h0);
    post_done(32'h5);
    op(C_DONE_RD, 32'h0, r);
    chk(r, 32'h5);
    op(C_DONE_RD, 32'h0, r);
    chk(r, 32'h0);
    // port write, six bytes
    wr(A_PORT, 32'h0001_0006);
    for (int i = 0; i < 3; i++) begin
      wait_st(ST_WAIT, 1'b1);
      wr(A_PWORD, {16'h0, 16'hC0D0 + 16'(i)});
    end
    wait_st(ST_BUSY, 1'b0);
    repeat (10) @(posedge clk);
    st_set(ST_EOT);
    chk({16'h0, m.cnt}, 32'h6);
    rd(A_STATUS, r);
    chk({16'h0, r[31:16]}, 32'h1);
    for (int i = 0; i < 3; i++) chk({16'h0, m.mem[i]}, {16'h0, 16'hC0D0 + 16'(i)});
    // port read, odd count rounds up
    wr(A_PORT, 32'h0000_0005);
    for (int i = 0; i < 3; i++) begin
      wait_st(ST_FULL, 1'b1);
      rd(A_PWORD, r);
      chk({16'h0, r[15:0]}, {16'h0, 16'hC0D0 + 16'(i)});
    end
    wait_st(ST_BUSY, 1'b0);
    chk({16'h0, m.cnt}, 32'h5);
    wr(A_PORT, 32'h0001_0101);
    st_set(ST_ERR);
    final_report();
  end
endmodule
`default_nettype wire
